// ---- rtl/acc_defines.svh ----
// Constants of the calibration and check core: offsets, fields, resets, timing.
// Assumes a 20 MHz core clock; included by bare name.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ==========================================================
// Map
`define ACC_NCH             6
`define ACC_NREG            39
`define ACC_ADDR_STATUS     8'h01
`define ACC_ADDR_MODE       8'h02
`define ACC_RMAP_FIRST      8'h02
`define ACC_RMAP_LAST       8'h26
`define ACC_CH_BASE         9
`define ACC_CH_STRIDE       5
`define ACC_ADDR_REGISTER_MAP_CHECK_VALUE 8'h3e

// ==========================================================
// Fields
`define ACC_MODE_REGCRC_BIT 13
`define ACC_MODE_RXCRC_BIT  12
`define ACC_MODE_TYPE_BIT   11

// ==========================================================
// Reset values and codes
`define ACC_OFS_RST         24'h000000
`define ACC_GAIN_RST        24'h800000
`define ACC_SAT_MAX         24'h7fffff
`define ACC_SAT_MIN         24'h800000
`define ACC_POLY_CCITT      16'h1021
`define ACC_POLY_ANSI       16'h8005
`define ACC_CRC_SEED        16'hffff

// ==========================================================
// Timing
`define ACC_CLK_PERIOD_NS   50
`define ACC_MOD_SETTLE      8
`define ACC_FAST_SAMPLES    2
`define ACC_OSR             1024
`define ACC_POR_TIME_NS     100000
`define ACC_POR_CYC         ((`ACC_POR_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_RSL_TIME_NS     2000
`define ACC_RSL_CYC         ((`ACC_RSL_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_DATA_READY_N_LOW_NS     400
`define ACC_DATA_READY_N_LOW_CYC    ((`ACC_DATA_READY_N_LOW_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)

`endif

// ---- rtl/acc_pkg.sv ----
// Types of the calibration and check core.
// Assumes acc_defines.svh is on the include path.
`default_nettype none
`include "acc_defines.svh"

package acc_pkg;

  // ==========================================================
  // Commands and phases
  typedef enum logic [1:0] {ACC_NULL, ACC_RREG, ACC_REGISTER_WRITE_CMD, ACC_RESET} acc_op_e;
  typedef enum logic [1:0] {ACC_POR, ACC_SETTLE, ACC_RUN} acc_ph_e;

  // ==========================================================
  // State of the core, apart from the reset release flops
  typedef struct packed {
    logic [1:0]                      mclk_s;
    logic                            mclk_prev;
    logic [1:0]                      rpin_s;
    logic [5:0]                      rsl_cnt;
    acc_ph_e                         ph;
    logic [11:0]                     por_cnt;
    logic [3:0]                      settle_cnt;
    logic [13:0]                     osr_cnt;
    logic [1:0]                      samp_idx;
    logic [3:0]                      data_ready_n_cnt;
    logic                            data_ready_n_n;
    logic [`ACC_NREG-1:0][15:0]      regs;
    logic                            crc_err;
    logic                            regmap_flag;
    logic [15:0]                     rx_crc;
    logic [15:0]                     tx_crc;
    logic [15:0]                     rm_acc;
    logic [15:0]                     rm_val;
    logic [5:0]                      rm_reg;
    logic [3:0]                      rm_bit;
    logic                            rm_valid;
    logic                            cal_valid;
    logic                            cal_fast;
    logic [`ACC_NCH-1:0][23:0]       cal;
    logic                            rsp_valid;
    logic [15:0]                     rsp_data;
  } acc_state_s;

endpackage : acc_pkg
`default_nettype wire

// ---- rtl/acc_core.sv ----
// Calibration, filter selection, frame check and register map check core.
// Assumes a frame shifter on core_clk feeding bits and decoded commands.
`default_nettype none
`include "acc_defines.svh"

module acc_core
  import acc_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire logic                       master_clock_in,
  input  wire logic                       sync_reset_n,
  input  wire logic [`ACC_NCH-1:0][23:0]  fast_results,
  input  wire logic [`ACC_NCH-1:0][23:0]  sinc_results,
  input  wire logic                       frm_start,
  input  wire logic                       rx_bit_valid,
  input  wire logic                       rx_bit,
  input  wire logic                       tx_bit_valid,
  input  wire logic                       tx_bit,
  input  wire logic                       frm_end,
  input  wire acc_op_e                    cmd_op,
  input  wire logic [7:0]                 cmd_addr,
  input  wire logic [15:0]                cmd_wdata,
  input  wire logic                       cmd_multi,
  input  wire logic [15:0]                rx_crc_word,
  output logic                            data_ready_n,
  output logic                            cal_valid,
  output logic                            cal_from_fast,
  output logic [`ACC_NCH-1:0][23:0]       cal_results,
  output logic                            rsp_valid,
  output logic [15:0]                     rsp_data,
  output logic [15:0]                     tx_crc
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] acc_crc_step(input logic [15:0] c, input logic b, input logic ansi);
    logic [15:0] p;
    p = ansi ? `ACC_POLY_ANSI : `ACC_POLY_CCITT;
    return (c[15] ^ b) ? ({c[14:0], 1'b0} ^ p) : {c[14:0], 1'b0};
  endfunction

  function automatic logic [23:0] acc_cal(input logic [23:0] x, input logic [23:0] ofs, input logic [23:0] gain);
    logic signed [24:0] d;
    logic signed [49:0] p;
    logic signed [26:0] q;
    d = $signed({x[23], x}) - $signed({ofs[23], ofs});
    p = d * $signed({1'b0, gain});
    q = p[49:23];
    if (q[26:23] != {4{q[23]}})
      return q[26] ? `ACC_SAT_MIN : `ACC_SAT_MAX;
    return q[23:0];
  endfunction

  function automatic logic [`ACC_NREG-1:0][15:0] acc_regs_rst();
    logic [`ACC_NREG-1:0][15:0] r;
    r = '0;
    for (int c = 0; c < `ACC_NCH; c++)
    begin
      r[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 1] = 16'(`ACC_OFS_RST >> 8);
      r[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 2] = 16'(`ACC_OFS_RST << 8);
      r[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 3] = 16'(`ACC_GAIN_RST >> 8);
      r[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 4] = 16'(`ACC_GAIN_RST << 8);
    end
    return r;
  endfunction

  function automatic acc_state_s acc_rst_state();
    acc_state_s r;
    r = '0;
    r.ph = ACC_POR;
    r.regs = acc_regs_rst();
    r.rx_crc = `ACC_CRC_SEED;
    r.tx_crc = `ACC_CRC_SEED;
    r.rm_acc = `ACC_CRC_SEED;
    r.rm_reg = 6'(`ACC_RMAP_FIRST);
    r.rm_bit = 4'hf;
    return r;
  endfunction

  localparam acc_state_s S_RST = acc_rst_state();

  // ==========================================================
  // Reset release
  logic [1:0] rst_q;
  logic       rst_n;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // ==========================================================
  // Decode
  acc_state_s                s;
  acc_state_s                n;
  logic                      mtick;
  logic                      rx_en;
  logic                      reg_crc_en;
  logic                      ansi;
  logic                      bad;
  logic                      exec;
  logic                      pin_rst;
  logic                      soft_rst;
  logic                      in_map;
  logic                      use_fast;
  logic [15:0]               status_w;
  logic [15:0]               rd_data;
  logic [15:0]               rm_next;
  logic [`ACC_NCH-1:0][23:0] cal_src;

  // Edge found only after the two-stage synchroniser
  assign mtick      = s.mclk_s[1] & ~s.mclk_prev;
  assign rx_en      = s.regs[`ACC_ADDR_MODE][`ACC_MODE_RXCRC_BIT];
  assign reg_crc_en = s.regs[`ACC_ADDR_MODE][`ACC_MODE_REGCRC_BIT];
  assign ansi       = s.regs[`ACC_ADDR_MODE][`ACC_MODE_TYPE_BIT];
  assign bad        = rx_en && (rx_crc_word != s.rx_crc);
  // Multi-register writes run unchecked; single writes are the safe form
  assign exec       = frm_end && (!bad || (cmd_op == ACC_REGISTER_WRITE_CMD && cmd_multi));
  assign pin_rst    = (s.rsl_cnt == 6'(`ACC_RSL_CYC));
  assign soft_rst   = pin_rst || (exec && cmd_op == ACC_RESET);
  assign in_map     = (cmd_addr >= `ACC_RMAP_FIRST) && (cmd_addr <= `ACC_RMAP_LAST);
  assign use_fast   = (s.samp_idx < 2'(`ACC_FAST_SAMPLES));
  assign cal_src    = use_fast ? fast_results : sinc_results;
  assign status_w   = {2'h0, s.regmap_flag, s.crc_err, 11'h000, ~s.data_ready_n_n};
  assign rm_next    = acc_crc_step(s.rm_acc, s.regs[s.rm_reg][s.rm_bit], ansi);

  always_comb
  begin
    if (cmd_addr == `ACC_ADDR_STATUS)
      rd_data = status_w;
    else if (cmd_addr == `ACC_ADDR_REGISTER_MAP_CHECK_VALUE)
      rd_data = s.rm_val;
    else if (in_map)
      rd_data = s.regs[cmd_addr[5:0]];
    else
      rd_data = 16'h0000;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    n = s;
    n.mclk_s = {s.mclk_s[0], master_clock_in};
    n.mclk_prev = s.mclk_s[1];
    n.rpin_s = {s.rpin_s[0], sync_reset_n};
    n.cal_valid = 1'b0;
    n.rsp_valid = 1'b0;

    // Short pin pulses are not a reset
    if (s.rpin_s[1])
      n.rsl_cnt = 6'h00;
    else if (!pin_rst)
      n.rsl_cnt = s.rsl_cnt + 6'h01;

    // Frame checks; padding bits arrive as ordinary bits
    if (frm_start)
    begin
      n.rx_crc = `ACC_CRC_SEED;
      n.tx_crc = `ACC_CRC_SEED;
    end
    else
    begin
      if (rx_bit_valid)
        n.rx_crc = acc_crc_step(s.rx_crc, rx_bit, ansi);
      if (tx_bit_valid)
        n.tx_crc = acc_crc_step(s.tx_crc, tx_bit, ansi);
    end

    if (s.data_ready_n_cnt != 4'h0)
    begin
      n.data_ready_n_cnt = s.data_ready_n_cnt - 4'h1;
      if (s.data_ready_n_cnt == 4'h1)
        n.data_ready_n_n = 1'b1;
    end

    unique case (s.ph)
      ACC_POR:
        if (s.por_cnt == 12'(`ACC_POR_CYC - 1))
        begin
          n.ph = ACC_SETTLE;
          n.data_ready_n_n = 1'b1;
        end
        else
          n.por_cnt = s.por_cnt + 12'h001;
      ACC_SETTLE:
        if (mtick)
        begin
          if (s.settle_cnt == 4'(`ACC_MOD_SETTLE - 1))
          begin
            n.ph = ACC_RUN;
            n.osr_cnt = 14'h0000;
          end
          else
            n.settle_cnt = s.settle_cnt + 4'h1;
        end
      ACC_RUN:
        if (mtick)
        begin
          if (s.osr_cnt == 14'(`ACC_OSR - 1))
          begin
            n.osr_cnt = 14'h0000;
            n.data_ready_n_n = 1'b0;
            n.data_ready_n_cnt = 4'(`ACC_DATA_READY_N_LOW_CYC);
            n.cal_valid = 1'b1;
            n.cal_fast = use_fast;
            if (use_fast)
              n.samp_idx = s.samp_idx + 2'h1;
            // No enable: correction sits in the only data path
            for (int c = 0; c < `ACC_NCH; c++)
              n.cal[c] = acc_cal(cal_src[c],
                {s.regs[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 1], s.regs[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 2][15:8]},
                {s.regs[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 3], s.regs[`ACC_CH_BASE + `ACC_CH_STRIDE * c + 4][15:8]});
          end
          else
            n.osr_cnt = s.osr_cnt + 14'h0001;
        end
      // Unused phase code: recover through settling
      default:
        n.ph = ACC_SETTLE;
    endcase

    // Commands; clears come before sets so a new event survives
    if (exec)
    begin
      unique case (cmd_op)
        ACC_NULL:
        begin
          n.rsp_valid = 1'b1;
          n.rsp_data = status_w;
          n.regmap_flag = 1'b0;
          n.crc_err = 1'b0;
        end
        ACC_RREG:
        begin
          n.rsp_valid = 1'b1;
          n.rsp_data = rd_data;
          if (cmd_addr == `ACC_ADDR_STATUS)
          begin
            n.regmap_flag = 1'b0;
            n.crc_err = 1'b0;
          end
        end
        ACC_REGISTER_WRITE_CMD:
          if (in_map)
            n.regs[cmd_addr[5:0]] = cmd_wdata;
        ACC_RESET:
          n.rsp_valid = 1'b0;
      endcase
    end
    if (frm_end && bad)
      n.crc_err = 1'b1;

    // Map check walks MSB of the first register to LSB of the last
    if (!reg_crc_en)
    begin
      n.rm_acc = `ACC_CRC_SEED;
      n.rm_reg = 6'(`ACC_RMAP_FIRST);
      n.rm_bit = 4'hf;
    end
    else if (mtick)
    begin
      if (s.rm_bit == 4'h0)
      begin
        n.rm_bit = 4'hf;
        if (s.rm_reg == 6'(`ACC_RMAP_LAST))
        begin
          n.rm_reg = 6'(`ACC_RMAP_FIRST);
          n.rm_acc = `ACC_CRC_SEED;
          n.rm_val = rm_next;
          n.rm_valid = 1'b1;
          if (s.rm_valid && rm_next != s.rm_val)
            n.regmap_flag = 1'b1;
        end
        else
        begin
          n.rm_reg = s.rm_reg + 6'h01;
          n.rm_acc = rm_next;
        end
      end
      else
      begin
        n.rm_bit = s.rm_bit - 4'h1;
        n.rm_acc = rm_next;
      end
    end

    // Pin or command reset skips the power-on wait
    if (soft_rst)
    begin
      n.regs = S_RST.regs;
      n.ph = ACC_SETTLE;
      n.settle_cnt = 4'h0;
      n.osr_cnt = 14'h0000;
      n.samp_idx = 2'h0;
      n.data_ready_n_n = 1'b1;
      n.data_ready_n_cnt = 4'h0;
      n.crc_err = 1'b0;
      n.regmap_flag = 1'b0;
      n.rm_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= S_RST;
    else
      s <= n;
  end

  assign data_ready_n  = s.data_ready_n_n;
  assign cal_valid     = s.cal_valid;
  assign cal_from_fast = s.cal_fast;
  assign cal_results   = s.cal;
  assign rsp_valid     = s.rsp_valid;
  assign rsp_data      = s.rsp_data;
  assign tx_crc        = s.tx_crc;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  por_release_a: assert property (
    $past(s.ph) == ACC_POR && s.ph == ACC_SETTLE |-> data_ready_n && !$past(data_ready_n))
    else $error("data ready did not rise at end of power-on wait");

  mod_settle_a: assert property (
    s.ph == ACC_SETTLE && mtick && s.settle_cnt == 4'd7 && !soft_rst |=> s.ph == ACC_RUN && s.osr_cnt == 14'h0)
    else $error("modulator settling not eight ticks");

  filter_pick_a: assert property (
    cal_valid |-> cal_from_fast == ($past(s.samp_idx) < 2'h2))
    else $error("wrong filter chosen for sample");

  data_ready_n_rate_a: assert property (
    $fell(data_ready_n) |-> $past(mtick) && $past(s.osr_cnt) == 14'd1023)
    else $error("data ready fell off the sample grid");

  crc_flag_a: assert property (
    frm_end && bad && !pin_rst |=> s.crc_err)
    else $error("check mismatch did not set error flag");

  crc_block_a: assert property (
    frm_end && bad && cmd_op != ACC_REGISTER_WRITE_CMD |=> !rsp_valid)
    else $error("command ran after check mismatch");

  rx_off_a: assert property (
    frm_end && !rx_en && !s.crc_err |=> !s.crc_err)
    else $error("error flag set with input check off");

  frame_seed_a: assert property (
    frm_start |=> tx_crc == 16'hffff)
    else $error("output check not seeded with ones");

  map_flag_a: assert property (
    reg_crc_en && mtick && s.rm_bit == 4'h0 && s.rm_reg == 6'h26 && s.rm_valid && rm_next != s.rm_val
    && !soft_rst |=> s.regmap_flag)
    else $error("map change not flagged");

  cmd_reset_a: assert property (
    exec && cmd_op == ACC_RESET |=> s.regs[12] == 16'h8000 && s.regs[10] == 16'h0000 && s.samp_idx == 2'h0)
    else $error("coefficients not at reset values");

endmodule // acc_core
`default_nettype wire

// ---- test/acc_host_model.sv ----
// Host side model: free-running master clock and the host's frame check.
// Assumes the bench drives frame strobes on core_clk rising edges.
`default_nettype none
`include "acc_defines.svh"

module acc_host_model
  import acc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        frm_start,
  input  wire logic        bit_valid,
  input  wire logic        bit_in,
  input  wire logic        poly_sel,
  output var  logic        master_clock_in,
  output logic [15:0]      host_crc
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic        fb;

  // ==========================================================
  // Master clock
  initial master_clock_in = 1'b0; // Starts with the supplies
  always #200 master_clock_in = ~master_clock_in;

  // ==========================================================
  // Frame check
  assign fb       = crc_q[15] ^ bit_in; // MSB first
  assign crc_d    = {crc_q[14:0], 1'b0} ^ (fb ? (poly_sel ? `ACC_POLY_ANSI : `ACC_POLY_CCITT) : 16'h0000);
  // Look-ahead value, so the bench can take it at the sampling edge
  assign host_crc = bit_valid ? crc_d : crc_q;

  always_ff @(posedge core_clk)
  begin
    if (frm_start)
      crc_q <= `ACC_CRC_SEED;
    else if (bit_valid)
      crc_q <= crc_d; // Padding bits too
  end
endmodule // acc_host_model
`default_nettype wire

// ---- test/acc_core_bench.sv ----
// Self-checking bench of the calibration and check core.
// Assumes acc_defines.svh on the include path and acc_host_model beside it.
`default_nettype none
`include "acc_defines.svh"

module acc_core_bench
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      core_clk = 1'b0;
  logic                      nrst = 1'b0;
  logic                      sync_reset_n = 1'b1;
  logic                      frm_start = 1'b0;
  logic                      rx_bit_valid = 1'b0;
  logic                      rx_bit = 1'b0;
  logic                      frm_end = 1'b0;
  logic                      cmd_multi = 1'b0;
  logic                      poly = 1'b0;
  acc_op_e                   cmd_op = ACC_NULL;
  logic [7:0]                cmd_addr = 8'h00;
  logic [15:0]               cmd_wdata = 16'h0000;
  logic [15:0]               rx_crc_word = 16'h0000;
  logic [`ACC_NCH-1:0][23:0] fast_v;
  logic [`ACC_NCH-1:0][23:0] sinc_v;
  logic [`ACC_NCH-1:0][23:0] cal_results;
  logic                      master_clock_in;
  logic                      data_ready_n;
  logic                      cal_valid;
  logic                      cal_from_fast;
  logic                      rsp_valid;
  logic [15:0]               rsp_data;
  logic [15:0]               tx_crc;
  logic [15:0]               host_crc;
  logic [15:0]               v0;
  logic                      got;
  logic [23:0]               ofs [`ACC_NCH];
  logic [23:0]               gn [`ACC_NCH];
  int                        num_errors = 0;
  int                        checks = 0;
  int                        cyc;
  int                        tick = 0;
  int                        t0;

  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) tick <= tick + 1;

  acc_host_model u_host (.core_clk, .frm_start, .bit_valid(rx_bit_valid), .bit_in(rx_bit),
                         .poly_sel(poly), .master_clock_in, .host_crc);

  // Output bits mirror input bits, so one reference covers both checks
  acc_core u_dut (.core_clk, .nrst, .master_clock_in, .sync_reset_n,
                  .fast_results(fast_v), .sinc_results(sinc_v), .frm_start, .rx_bit_valid, .rx_bit,
                  .tx_bit_valid(rx_bit_valid), .tx_bit(rx_bit), .frm_end, .cmd_op, .cmd_addr, .cmd_wdata,
                  .cmd_multi, .rx_crc_word, .data_ready_n, .cal_valid, .cal_from_fast, .cal_results,
                  .rsp_valid, .rsp_data, .tx_crc);

  // ==========================================================
  // Checks and expectations
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [23:0] cal_exp(input int c, input logic f);
    logic [23:0]        x;
    logic signed [49:0] p;
    x = f ? fast_v[c] : sinc_v[c];
    p = ($signed({x[23], x}) - $signed({ofs[c][23], ofs[c]})) * $signed({1'b0, gn[c]});
    p = p >>> 23;
    if (p > 50'sd8388607)
      return 24'h7fffff;
    if (p < -50'sd8388608)
      return 24'h800000;
    return p[23:0];
  endfunction

  task automatic defaults();
    for (int c = 0; c < `ACC_NCH; c++)
    begin
      ofs[c] = `ACC_OFS_RST;
      gn[c]  = `ACC_GAIN_RST;
    end
  endtask

  // ==========================================================
  // Frame access
  task automatic send(input acc_op_e op, input logic [7:0] a, input logic [15:0] d, input logic m,
                      input logic bad);
    logic [31:0] w;
    w   = {8'h00, a, d};
    got = 1'b0;
    @(posedge core_clk);
    frm_start <= 1'b1;
    @(posedge core_clk);
    frm_start <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      rx_bit_valid <= 1'b1;
      rx_bit       <= w[i];
      @(posedge core_clk);
    end
    rx_bit_valid <= 1'b0;
    frm_end      <= 1'b1;
    cmd_op       <= op;
    cmd_addr     <= a;
    cmd_wdata    <= d;
    cmd_multi    <= m;
    rx_crc_word  <= host_crc ^ {15'h0000, bad};
    @(posedge core_clk);
    frm_end <= 1'b0;
    for (int i = 0; i < 3 && !got; i++)
    begin
      #1;
      if (rsp_valid === 1'b1)
        got = 1'b1;
      else
        @(posedge core_clk);
    end
    chk({8'h00, tx_crc}, {8'h00, host_crc});
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    send(ACC_RREG, a, 16'h0000, 1'b0, 1'b0);
    chk({23'h0, got}, 24'h1);
    chk({8'h00, rsp_data & m}, {8'h00, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    send(ACC_REGISTER_WRITE_CMD, a, d, 1'b0, 1'b0);
  endtask

  task automatic set_cal(input int c, input logic [23:0] o, input logic [23:0] g);
    logic [7:0] b;
    b = 8'(`ACC_CH_BASE + `ACC_CH_STRIDE * c);
    wr(b + 8'h01, o[23:8]);
    wr(b + 8'h02, {o[7:0], 8'h00});
    wr(b + 8'h03, g[23:8]);
    wr(b + 8'h04, {g[7:0], 8'h00});
    ofs[c] = o;
    gn[c]  = g;
  endtask

  task automatic wait_sample(input logic f, input int lo, input int hi);
    cyc = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    while (cal_valid !== 1'b1 && cyc < 9000);
    if (cyc >= 9000)
    begin
      num_errors++;
      $display("[FAIL] %0t no sample", $time);
      finish_test();
    end
    else
    begin
      chk({23'h0, cyc >= lo && cyc <= hi}, 24'h1);
      chk({23'h0, data_ready_n}, 24'h0);
      chk({23'h0, cal_from_fast}, {23'h0, f});
      for (int c = 0; c < `ACC_NCH; c++)
        chk(cal_results[c], cal_exp(c, f));
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    for (int c = 0; c < `ACC_NCH; c++)
    begin
      fast_v[c] = c[0] ? 24'ha00000 + 24'(c) : 24'h600000 + 24'(c);
      sinc_v[c] = fast_v[c] ^ 24'h000f0f;
    end
    defaults();
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    cyc = 0;
    while (data_ready_n !== 1'b1 && cyc < 2100)
    begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    if (cyc >= 2100)
    begin
      num_errors++;
      $display("[FAIL] %0t no power-on release", $time);
      finish_test();
    end
    t0 = tick;
    chk({23'h0, cyc >= 1995 && cyc <= 2010}, 24'h1);
    rd(`ACC_ADDR_MODE, 16'hffff, 16'h0000);
    rd(8'h0c, 16'hffff, 16'h8000);
    rd(8'h0a, 16'hffff, 16'h0000);
    wr(`ACC_ADDR_MODE, 16'h2000);
    set_cal(1, 24'h001000, 24'h400000);
    set_cal(2, 24'h000000, 24'hffffff);
    set_cal(3, 24'h7fffff, 24'h800000);
    wait_sample(1'b1, 0, 9000);
    chk({23'h0, tick - t0 >= 8240 && tick - t0 <= 8290}, 24'h1);
    wait_sample(1'b1, 8185, 8200);
    rd(`ACC_ADDR_STATUS, 16'h1001, 16'h0000);
    rd(`ACC_ADDR_STATUS, 16'h2000, 16'h0000);
    rd(`ACC_ADDR_REGISTER_MAP_CHECK_VALUE, 16'h0000, 16'h0000);
    v0 = rsp_data;
    wr(8'h09, 16'h00a5);
    wait_sample(1'b0, 0, 9000);
    rd(`ACC_ADDR_STATUS, 16'h2000, 16'h2000);
    rd(`ACC_ADDR_REGISTER_MAP_CHECK_VALUE, 16'h0000, 16'h0000);
    chk({23'h0, rsp_data !== v0}, 24'h1);
    // Input check on: a corrupt single write must not land
    wr(`ACC_ADDR_MODE, 16'h3000);
    send(ACC_REGISTER_WRITE_CMD, 8'h20, 16'h1234, 1'b0, 1'b1);
    rd(8'h20, 16'hffff, 16'h8000);
    rd(`ACC_ADDR_STATUS, 16'h1000, 16'h1000);
    send(ACC_REGISTER_WRITE_CMD, 8'h20, 16'h1234, 1'b1, 1'b1);
    rd(8'h20, 16'hffff, 16'h1234);
    rd(`ACC_ADDR_STATUS, 16'h1000, 16'h1000);
    send(ACC_RREG, 8'h02, 16'h0000, 1'b0, 1'b1);
    chk({23'h0, got}, 24'h0);
    send(ACC_NULL, 8'h00, 16'h0000, 1'b0, 1'b0);
    chk({8'h00, rsp_data & 16'h1000}, 24'h001000);
    rd(`ACC_ADDR_STATUS, 16'h1000, 16'h0000);
    wr(`ACC_ADDR_MODE, 16'h3800);
    poly = 1'b1;
    rd(`ACC_ADDR_MODE, 16'hffff, 16'h3800);
    // Pin reset: no power-on wait, fast filter again
    @(posedge core_clk);
    sync_reset_n <= 1'b0;
    repeat (50) @(posedge core_clk);
    sync_reset_n <= 1'b1;
    t0   = tick;
    poly = 1'b0;
    defaults();
    repeat (5) @(posedge core_clk);
    rd(`ACC_ADDR_MODE, 16'hffff, 16'h0000);
    rd(8'h20, 16'hffff, 16'h8000);
    wait_sample(1'b1, 0, 9000);
    chk({23'h0, tick - t0 >= 8250 && tick - t0 <= 8310}, 24'h1);
    set_cal(1, 24'h000200, 24'h900000);
    send(ACC_RESET, 8'h00, 16'h0000, 1'b0, 1'b0);
    defaults();
    repeat (5) @(posedge core_clk);
    rd(8'h11, 16'hffff, 16'h8000);
    wait_sample(1'b1, 0, 9000);
    finish_test();
  end
endmodule // acc_core_bench
`default_nettype wire
